// *** core/cwg_pkg.sv ***
// Package for the complementary waveform generator: register map, field
// positions, reset values, modes and the carrier structs.
// Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
package cwg_pkg;

    // Register byte offsets.
    localparam logic [7:0] CWG_OFS_CTRL   = 8'h00;
    localparam logic [7:0] CWG_OFS_POL    = 8'h04;
    localparam logic [7:0] CWG_OFS_DBR    = 8'h08;
    localparam logic [7:0] CWG_OFS_DBF    = 8'h0c;
    localparam logic [7:0] CWG_OFS_SDCTL  = 8'h10;
    localparam logic [7:0] CWG_OFS_SDSRC  = 8'h14;
    localparam logic [7:0] CWG_OFS_STEER  = 8'h18;
    localparam logic [7:0] CWG_OFS_CLK    = 8'h1c;
    localparam logic [7:0] CWG_OFS_ISEL   = 8'h20;

    // Field positions.
    localparam int CWG_BIT_EN       = 7;
    localparam int CWG_BIT_LD       = 6;
    localparam int CWG_BIT_IN       = 5;
    localparam int CWG_BIT_SHUTDOWN = 7;
    localparam int CWG_BIT_REN      = 6;
    localparam int CWG_POS_BD_SHUTDOWN_LEVEL     = 4;
    localparam int CWG_POS_AC_SHUTDOWN_LEVEL     = 2;

    // Reset values of the 2-bit shutdown level fields.
    localparam logic [1:0] CWG_RST_BD_SHUTDOWN_LEVEL = 2'h1;
    localparam logic [1:0] CWG_RST_AC_SHUTDOWN_LEVEL = 2'h1;

    // Shutdown level encodings.
    localparam logic [1:0] CWG_LVL_INACT = 2'h0;
    localparam logic [1:0] CWG_LVL_TRI   = 2'h1;
    localparam logic [1:0] CWG_LVL_LOW   = 2'h2;
    localparam logic [1:0] CWG_LVL_HIGH  = 2'h3;

    // Number of selectable modulating sources; codes above read as nothing.
    localparam int CWG_NUM_SRC = 14;

    // Output modes.
    typedef enum logic [2:0] {
        CWG_MODE_STEER  = 3'h0,
        CWG_MODE_SSTEER = 3'h1,
        CWG_MODE_FWD    = 3'h2,
        CWG_MODE_REV    = 3'h3,
        CWG_MODE_HALF   = 3'h4,
        CWG_MODE_PP     = 3'h5
    } cwg_mode_t;

    // Drive of the four outputs, index 0 is A and 3 is D.
    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] oe;
    } cwg_out_t;

    // Active-low fault sources.
    typedef struct packed {
        logic extra_n;
        logic cmp2_n;
        logic cmp1_n;
        logic timer_n;
        logic pin_n;
    } cwg_fault_t;

endpackage

// *** core/cwg_top.sv ***
// Complementary waveform generator with AHB-Lite register slave.
// Assumes modulating sources, fault inputs and the oscillator tick are
// asynchronous to hclk; the outputs drive external bridge driver stages.
`timescale 1ns/1ns
module cwg_top
    import cwg_pkg::*;
(
    // Clock and reset.
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // AHB-Lite slave.
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic [31:0]                 hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    // Waveform inputs.
    input  wire logic [CWG_NUM_SRC-1:0] modulating_source,
    input  wire cwg_fault_t             fault_in,
    input  wire logic                   fast_internal_osc,
    // Bridge outputs.
    output cwg_out_t                    wave_out
);

    // Two-flop synchronisers for every asynchronous input.
    logic [CWG_NUM_SRC-1:0] src_m_q, src_s_q;
    cwg_fault_t             flt_m_q, flt_s_q;
    logic                   osc_m_q, osc_s_q, osc_d_q;

    // Registers.
    logic       en_q, ld_q, shutdown_q, ren_q, cs_q;
    cwg_mode_t  mode_q;
    logic [3:0] pol_q, ovr_q, str_q, str_act_q, isel_q;
    logic [4:0] fault_en_q;
    logic [1:0] bd_shutdown_level_q, ac_shutdown_level_q;
    logic [5:0] dbr_q, dbf_q, dbr_act_q, dbf_act_q;

    // Bus and waveform state.
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rdata_q;
    logic        data_q, hold_q, pp_q, pri_q, sec_q;
    logic [5:0]  rcnt_q, fcnt_q;
    logic        rpend_q, fpend_q;
    cwg_out_t    out_q;

    // Combinational helpers.
    logic       sel_data, rise_evt, fall_evt, tick, fault_act, acc, wr_now;
    logic       sd_eff, pending_sd_set;
    logic [3:0] wave, drive;

    // Chooses the shutdown drive of one pin from its 2-bit level field.
    function automatic logic [1:0] sd_pin(input logic [1:0] lvl, input logic pol);
        logic [1:0] r;
        r = 2'h0;
        case (lvl)
            CWG_LVL_HIGH: r = 2'h3;
            CWG_LVL_LOW:  r = 2'h2;
            CWG_LVL_TRI:  r = 2'h0;
            default:      r = {1'b1, pol};
        endcase
        return r;
    endfunction

    // Synchroniser stages; logic reads the second stage, and osc_d_q for the oscillator edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_m_q <= '0;
            src_s_q <= '0;
            flt_m_q <= '1;
            flt_s_q <= '1;
            osc_m_q <= 1'b0;
            osc_s_q <= 1'b0;
            osc_d_q <= 1'b0;
        end else begin
            src_m_q <= modulating_source;
            src_s_q <= src_m_q;
            flt_m_q <= fault_in;
            flt_s_q <= flt_m_q;
            osc_m_q <= fast_internal_osc;
            osc_s_q <= osc_m_q;
            osc_d_q <= osc_s_q;
        end
    end

    // Source select: codes past the last source connect nothing.
    assign sel_data = (isel_q < 4'(CWG_NUM_SRC)) ? src_s_q[isel_q] : 1'b0;
    // The dead-band counters run on every hclk or on each oscillator rising edge.
    assign tick = cs_q ? (osc_s_q & ~osc_d_q) : 1'b1;
    assign rise_evt = en_q & sel_data & ~data_q;
    assign fall_evt = en_q & ~sel_data & data_q;
    // Faults are active low and level sensitive.
    assign fault_act = |(fault_en_q & ~flt_s_q);

    // Bus address phase capture; one cycle later the data phase completes.
    assign acc    = hsel & hready & htrans[1];
    assign wr_now = wr_pend_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= acc & hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    // Read data is registered at the address phase so it stands in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h00000000;
        end else if (acc && !hwrite) begin
            case (haddr[7:0])
                CWG_OFS_CTRL:  rdata_q <= {24'h0, en_q, ld_q, 3'h0, mode_q};
                CWG_OFS_POL:   rdata_q <= {26'h0, data_q, 1'b0, pol_q};
                CWG_OFS_DBR:   rdata_q <= {26'h0, dbr_q};
                CWG_OFS_DBF:   rdata_q <= {26'h0, dbf_q};
                CWG_OFS_SDCTL: rdata_q <= {24'h0, shutdown_q, ren_q, bd_shutdown_level_q, ac_shutdown_level_q, 2'h0};
                CWG_OFS_SDSRC: rdata_q <= {27'h0, fault_en_q};
                CWG_OFS_STEER: rdata_q <= {24'h0, ovr_q, str_q};
                CWG_OFS_CLK:   rdata_q <= {31'h0, cs_q};
                CWG_OFS_ISEL:  rdata_q <= {28'h0, isel_q};
                default:       rdata_q <= 32'h00000000;
            endcase
        end
    end

    // Plain configuration registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q       <= 1'b0;
            mode_q     <= CWG_MODE_STEER;
            pol_q      <= 4'h0;
            ren_q      <= 1'b0;
            bd_shutdown_level_q     <= CWG_RST_BD_SHUTDOWN_LEVEL;
            ac_shutdown_level_q     <= CWG_RST_AC_SHUTDOWN_LEVEL;
            fault_en_q <= 5'h00;
            ovr_q      <= 4'h0;
            str_q      <= 4'h0;
            cs_q       <= 1'b0;
            isel_q     <= 4'h0;
        end else if (wr_now) begin
            case (wr_addr_q)
                CWG_OFS_CTRL: begin
                    en_q   <= hwdata[CWG_BIT_EN];
                    mode_q <= cwg_mode_t'(hwdata[2:0]);
                end
                CWG_OFS_POL:   pol_q <= hwdata[3:0];
                CWG_OFS_SDCTL: begin
                    ren_q  <= hwdata[CWG_BIT_REN];
                    bd_shutdown_level_q <= hwdata[CWG_POS_BD_SHUTDOWN_LEVEL +: 2];
                    ac_shutdown_level_q <= hwdata[CWG_POS_AC_SHUTDOWN_LEVEL +: 2];
                end
                CWG_OFS_SDSRC: fault_en_q <= hwdata[4:0];
                CWG_OFS_STEER: begin
                    ovr_q <= hwdata[7:4];
                    str_q <= hwdata[3:0];
                end
                CWG_OFS_CLK:   cs_q   <= hwdata[0];
                CWG_OFS_ISEL:  isel_q <= hwdata[3:0];
                default: ;
            endcase
        end
    end

    // Dead-band buffers have no reset so that a warm reset keeps them.
    always_ff @(posedge hclk) begin
        if (wr_now && wr_addr_q == CWG_OFS_DBR) begin
            dbr_q <= hwdata[5:0];
        end
        if (wr_now && wr_addr_q == CWG_OFS_DBF) begin
            dbf_q <= hwdata[5:0];
        end
    end

    // Load request: a write only sets it when enable was already on, so the
    // enabling write cannot arm it. A request write beats the hardware clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ld_q <= 1'b0;
        end else if (wr_now && wr_addr_q == CWG_OFS_CTRL && hwdata[CWG_BIT_LD] && en_q) begin
            ld_q <= hwdata[CWG_BIT_EN];
        end else if (!en_q || rise_evt || fall_evt) begin
            ld_q <= 1'b0;
        end
    end

    // Active dead-band values: track the buffers while disabled, else load on request.
    always_ff @(posedge hclk) begin
        if (!en_q || (ld_q && (rise_evt || fall_evt))) begin
            dbr_act_q <= dbr_q;
            dbf_act_q <= dbf_q;
        end
    end

    // Shutdown status: a fault sets it and wins over any clear; clearing by
    // software or by auto-restart is blocked while a fault persists.
    assign pending_sd_set = wr_now && wr_addr_q == CWG_OFS_SDCTL && hwdata[CWG_BIT_SHUTDOWN];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shutdown_q <= 1'b0;
        end else if (fault_act || pending_sd_set) begin
            shutdown_q <= 1'b1;
        end else if (wr_now && wr_addr_q == CWG_OFS_SDCTL) begin
            shutdown_q <= 1'b0;
        end else if (ren_q && rise_evt) begin
            shutdown_q <= 1'b0;
        end
    end

    // Overrides hold after the clear until the next rising input edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= 1'b0;
        end else if (shutdown_q) begin
            hold_q <= 1'b1;
        end else if (rise_evt) begin
            hold_q <= 1'b0;
        end
    end
    assign sd_eff = shutdown_q | hold_q;

    // Steering enables in use: immediate in plain steering, taken on the rising
    // edge in synchronous steering so no waveform is cut short.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            str_act_q <= 4'h0;
        end else if (mode_q != CWG_MODE_SSTEER || !en_q || rise_evt) begin
            str_act_q <= str_q;
        end
    end

    // Input edge tracking, push-pull phase and dead-band counters. The primary
    // leg turns on a rising dead band after the rise, the secondary a falling
    // dead band after the fall; each turns off at once on the opposite edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_q  <= 1'b0;
            pp_q    <= 1'b0;
            pri_q   <= 1'b0;
            sec_q   <= 1'b0;
            rcnt_q  <= 6'h00;
            fcnt_q  <= 6'h00;
            rpend_q <= 1'b0;
            fpend_q <= 1'b0;
        end else begin
            data_q <= sel_data;
            if (rise_evt) begin
                pp_q    <= ~pp_q;
                sec_q   <= 1'b0;
                fpend_q <= 1'b0;
                rpend_q <= 1'b1;
                rcnt_q  <= dbr_act_q;
            end else if (fall_evt) begin
                pri_q   <= 1'b0;
                rpend_q <= 1'b0;
                fpend_q <= 1'b1;
                fcnt_q  <= dbf_act_q;
            end else if (tick) begin
                if (rpend_q && rcnt_q == 6'h00) begin
                    pri_q   <= 1'b1;
                    rpend_q <= 1'b0;
                end else if (rpend_q) begin
                    rcnt_q <= rcnt_q - 6'h01;
                end
                if (fpend_q && fcnt_q == 6'h00) begin
                    sec_q   <= 1'b1;
                    fpend_q <= 1'b0;
                end else if (fpend_q) begin
                    fcnt_q <= fcnt_q - 6'h01;
                end
            end
        end
    end

    // Raw waveform per output before polarity, selected by mode.
    always_comb begin
        wave = 4'h0;
        case (mode_q)
            CWG_MODE_STEER, CWG_MODE_SSTEER: wave = {4{data_q}};
            CWG_MODE_FWD:  wave = {pri_q, 1'b0, 1'b0, 1'b1};
            CWG_MODE_REV:  wave = {1'b0, 1'b1, pri_q, 1'b0};
            CWG_MODE_HALF: wave = {sec_q, pri_q, sec_q, pri_q};
            CWG_MODE_PP:   wave = {1'b0, 1'b0, pri_q & ~pp_q, pri_q & pp_q};
            default:       wave = 4'h0;
        endcase
    end

    // Polarity and steering; fixed data applies only in the steering modes.
    always_comb begin
        drive = wave ^ pol_q;
        if (mode_q == CWG_MODE_STEER || mode_q == CWG_MODE_SSTEER) begin
            drive = (str_act_q & (wave ^ pol_q)) | (~str_act_q & ovr_q);
        end
    end

    // Output register: shutdown overrides take the pins, polarity aside except
    // for the inactive level. In steering, fixed pins are not overridden.
    always_ff @(posedge hclk or negedge hresetn) begin
        logic [1:0] s;
        logic       steer;
        if (!hresetn) begin
            out_q <= '{lvl: 4'h0, oe: 4'h0};
        end else begin
            steer = (mode_q == CWG_MODE_STEER) || (mode_q == CWG_MODE_SSTEER);
            for (int i = 0; i < 4; i++) begin
                s = sd_pin((i % 2 == 1) ? bd_shutdown_level_q : ac_shutdown_level_q, pol_q[i]);
                if (sd_eff && !(steer && !str_act_q[i])) begin
                    out_q.oe[i]  <= s[1];
                    out_q.lvl[i] <= s[0];
                end else begin
                    out_q.oe[i]  <= en_q;
                    out_q.lvl[i] <= en_q & drive[i];
                end
            end
        end
    end
    assign wave_out = out_q;

    // Assertions.
    a_ld_needs_en: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(en_q) |-> !(ld_q && !$past(ld_q)))
        else $error("load request armed while disabled");
    a_ld_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        (ld_q && rise_evt && !wr_now) |=> !ld_q)
        else $error("load request not cleared at input edge");
    a_db_transfer: assert property (@(posedge hclk) disable iff (!hresetn)
        (en_q && ld_q && rise_evt) |=> dbr_act_q == $past(dbr_q))
        else $error("dead band not transferred");
    a_fault_sets_sd: assert property (@(posedge hclk) disable iff (!hresetn)
        fault_act |=> shutdown_q)
        else $error("fault did not set shutdown");
    a_fault_sync_delay: assert property (@(posedge hclk) disable iff (!hresetn)
        (fault_en_q[0] && !fault_in.pin_n) [*3] |-> ##1 shutdown_q)
        else $error("pin fault did not reach shutdown in three cycles");
    a_hold_until_rise: assert property (@(posedge hclk) disable iff (!hresetn)
        ($fell(shutdown_q) && !rise_evt) |=> hold_q)
        else $error("overrides released before rising edge");
    a_sd_level_high: assert property (@(posedge hclk) disable iff (!hresetn)
        (sd_eff && bd_shutdown_level_q == CWG_LVL_HIGH && str_act_q[1])
        |=> out_q.lvl[1] && out_q.oe[1])
        else $error("output B not high in shutdown");
    a_sd_level_tri: assert property (@(posedge hclk) disable iff (!hresetn)
        (sd_eff && ac_shutdown_level_q == CWG_LVL_TRI && str_act_q[0]) |=> !out_q.oe[0])
        else $error("output A not released in shutdown");
    a_steer_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
        (en_q && !sd_eff && mode_q == CWG_MODE_STEER && !str_act_q[2])
        |=> out_q.lvl[2] == $past(ovr_q[2]))
        else $error("fixed steering data not driven");
    a_steer_sync: assert property (@(posedge hclk) disable iff (!hresetn)
        (en_q && mode_q == CWG_MODE_SSTEER && !rise_evt) |=> $stable(str_act_q))
        else $error("synchronous steering changed off edge");
    a_no_restart_fault: assert property (@(posedge hclk) disable iff (!hresetn)
        (shutdown_q && fault_act) |=> shutdown_q)
        else $error("shutdown cleared under active fault");

    c_load_done:  cover property (@(posedge hclk) disable iff (!hresetn) ld_q ##1 !ld_q);
    c_auto_rest:  cover property (@(posedge hclk) disable iff (!hresetn)
        ren_q && $fell(shutdown_q));
    c_halfbridge: cover property (@(posedge hclk) disable iff (!hresetn)
        mode_q == CWG_MODE_HALF && pri_q ##[1:200] sec_q);

endmodule

// *** dv/cwg_bridge_model.sv ***
// Behavioural model of the bridge driver stages at the far side of the generator.
// Assumes the bench commands fault requests; released pins float away from their last level.
`timescale 1ns/1ns
module cwg_bridge_model
    import cwg_pkg::*;
(
    // From the generator.
    input  wire cwg_out_t   wave_out,
    // Fault requests from the bench, one per source.
    input  wire logic [4:0] fault_req,
    // Toward the generator and the bench.
    output cwg_fault_t      fault_in,
    output logic [3:0]      pin_level
);
    logic [3:0] last_q;

    // A requested fault pulls its line low and holds it at that level.
    assign fault_in = cwg_fault_t'(~fault_req);

    // Remember the last driven level so a released pin shows its inverse, not a lucky match.
    always @* begin
        for (int i = 0; i < 4; i++) begin
            if (wave_out.oe[i]) begin
                last_q[i] = wave_out.lvl[i];
            end
        end
    end

    // Resolve each pin from the drive and its enable.
    assign pin_level = (wave_out.oe & wave_out.lvl) | (~wave_out.oe & ~last_q);
endmodule

// *** dv/tb_complementary_waveform_generator.sv ***
// Self-checking bench for the waveform generator: bus tasks, one task per scenario.
// Assumes a zero-wait AHB-Lite slave and the bridge model on the output side.
`timescale 1ns/1ns
module tb_complementary_waveform_generator
    import cwg_pkg::*;
;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, osc = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic [13:0] src = 14'h0;
    logic [4:0]  fault_req = 5'h0;
    logic        hreadyout;
    cwg_fault_t  fault_in;
    cwg_out_t    wave_out;
    logic [3:0]  pin_level;
    int          fails = 0, n_compared = 0, cyc = 0;

    cwg_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .modulating_source(src), .fault_in(fault_in), .fast_internal_osc(osc),
        .wave_out(wave_out));
    cwg_bridge_model i_bridge (.wave_out(wave_out), .fault_req(fault_req),
        .fault_in(fault_in), .pin_level(pin_level));

    // Bus clock and an unrelated oscillator; no scenario runs a dead band on its tick.
    always #10 hclk = ~hclk;
    always #31 osc = ~osc;

    // Hang guard well above the expected run length.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One single transfer; only the bench's cycle ceiling ends a wait on a dead slave.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wt(input int n); repeat (n) @(posedge hclk); endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d); bus(1'b1, a, {24'h0, d}); endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, {24'h0, e});
    endtask
    task automatic chkw(input logic [7:0] e); chk({24'h0, wave_out}, {24'h0, e}); endtask
    // Inputs pass two sync flops and an edge detector, so eight cycles settle them.
    task automatic sv(input logic [13:0] s);
        @(posedge hclk);
        src <= s;
        wt(8);
    endtask
    task automatic fl(input logic [4:0] f);
        @(posedge hclk);
        fault_req <= f;
        wt(8);
    endtask

    task automatic t_regs();
        logic [7:0] ofs [7] = '{CWG_OFS_CLK, CWG_OFS_ISEL, CWG_OFS_SDSRC, CWG_OFS_DBR,
                                CWG_OFS_DBF, CWG_OFS_STEER, 8'h24};
        logic [7:0] wv [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hc0, 8'ha5, 8'hff};
        logic [7:0] ev [7] = '{8'h01, 8'h0f, 8'h1f, 8'h3f, 8'h00, 8'ha5, 8'h00};
        rdc(CWG_OFS_SDCTL, 8'h14);
        rdc(CWG_OFS_CTRL, 8'h00);
        rdc(CWG_OFS_POL, 8'h00);
        for (int i = 0; i < 7; i++) begin
            if (i != 3 && i != 4) rdc(ofs[i], 8'h00);
            wr(ofs[i], wv[i]);
            rdc(ofs[i], ev[i]);
            wr(ofs[i], 8'h00);
        end
        $display("register map test done");
    endtask

    task automatic t_input();
        sv(14'h8);
        wr(CWG_OFS_ISEL, 8'h03);
        wt(4);
        rdc(CWG_OFS_POL, 8'h20);
        wr(CWG_OFS_ISEL, 8'h0e);
        wt(4);
        rdc(CWG_OFS_POL, 8'h00);
        wr(CWG_OFS_ISEL, 8'h00);
        sv(14'h0);
        $display("input select test done");
    endtask

    task automatic t_load();
        wr(CWG_OFS_CTRL, 8'hc0);
        rdc(CWG_OFS_CTRL, 8'h80);
        wr(CWG_OFS_CTRL, 8'hc0);
        rdc(CWG_OFS_CTRL, 8'hc0);
        sv(14'h1);
        rdc(CWG_OFS_CTRL, 8'h80);
        sv(14'h0);
        $display("load request test done");
    endtask

    task automatic t_steer();
        wr(CWG_OFS_POL, 8'h01);
        wr(CWG_OFS_STEER, 8'h25);
        sv(14'h1);
        chkw(8'h6f);
        sv(14'h0);
        chkw(8'h3f);
        wr(CWG_OFS_CTRL, 8'h81);
        sv(14'h1);
        wr(CWG_OFS_STEER, 8'h20);
        wt(8);
        chkw(8'h6f);
        sv(14'h0);
        sv(14'h1);
        chkw(8'h2f);
        $display("steering test done");
    endtask

    task automatic t_mode();
        wr(CWG_OFS_POL, 8'h00);
        wr(CWG_OFS_STEER, 8'hf0);
        wr(CWG_OFS_CTRL, 8'h82);
        sv(14'h0);
        chkw(8'h1f);
        for (int m = 0; m < 8; m++) begin
            wr(CWG_OFS_CTRL, 8'h80 | m[7:0]);
            rdc(CWG_OFS_CTRL, 8'h80 | m[7:0]);
        end
        wr(CWG_OFS_CTRL, 8'h80);
        $display("mode test done");
    endtask

    task automatic t_shut();
        wr(CWG_OFS_STEER, 8'h0f);
        sv(14'h0);
        chkw(8'h0f);
        wr(CWG_OFS_SDSRC, 8'h01);
        wr(CWG_OFS_SDCTL, 8'h38);
        fl(5'h01);
        rdc(CWG_OFS_SDCTL, 8'hb8);
        chkw(8'haf);
        wr(CWG_OFS_SDCTL, 8'h38);
        rdc(CWG_OFS_SDCTL, 8'hb8);
        fl(5'h00);
        wr(CWG_OFS_SDCTL, 8'h38);
        rdc(CWG_OFS_SDCTL, 8'h38);
        wt(8);
        chkw(8'haf);
        sv(14'h1);
        chkw(8'hff);
        wr(CWG_OFS_SDCTL, 8'ha4);
        wt(4);
        chk({28'h0, wave_out.oe}, 32'ha);
        chk({28'h0, pin_level & 4'ha}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(CWG_OFS_SDCTL, 8'h78);
            wr(CWG_OFS_SDSRC, 8'h01 << i);
            fl(5'h01 << ((i + 1) % 5));
            rdc(CWG_OFS_SDCTL, 8'h78);
            fl(5'h01 << i);
            rdc(CWG_OFS_SDCTL, 8'hf8);
            fl(5'h00);
            sv(14'h0);
            sv(14'h1);
            rdc(CWG_OFS_SDCTL, 8'h78);
        end
        // The overrides stay on after the automatic clear until one more rising edge.
        sv(14'h0);
        sv(14'h1);
        chkw(8'hff);
        wr(CWG_OFS_SDSRC, 8'h00);
        wr(CWG_OFS_SDCTL, 8'h38);
        $display("shutdown test done");
    endtask

    task automatic t_dis();
        wr(CWG_OFS_CTRL, 8'h00);
        wt(4);
        chkw(8'h00);
        wr(CWG_OFS_SDCTL, 8'hb8);
        wt(4);
        chkw(8'haf);
        $display("disabled shutdown test done");
    endtask

    // Reset for eight cycles, then run the scenarios in order.
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_input();
        t_load();
        t_steer();
        t_mode();
        t_shut();
        t_dis();
        final_report();
    end
endmodule
